// *** hdl/sensor_i2c_slave_link.sv ***
// two-wire slave link: bit, byte and addressing layer of the sensor
`timescale 1ns/1ps

module sensor_i2c_slave_link
  import sensor_i2c_pkg::*;
#(
  parameter int unsigned MODE_SEL_CYCLES = int'(MODE_SEL_CYC)
)(
  input  wire logic      clk_sys,          // system clock
  input  wire logic      rstn,             // async reset, active low
  input  wire logic      ce,               // clock enable, freezes state
  input  wire logic      clk_link,         // link-side sampling clock
  input  wire logic      scl_i,            // serial clock pin level
  input  wire logic      sda_i,            // serial data pin level
  output logic           sda_o,            // data pin drive value
  output logic           sda_oe,           // data pin pull-low enable
  output logic           single_wire_mode, // power-up mode choice
  output logic           rx_valid,         // event pulse
  output link_evt_t      rx_evt,           // event kind and byte
  input  wire logic      rx_accept,        // may take more write bytes
  input  wire logic      tx_valid,         // read byte offered
  input  wire logic [7:0] tx_data,         // read byte
  output logic           tx_ready          // read byte slot free
);

  localparam int CW = $clog2(MODE_SEL_CYCLES + 1);

  if (MODE_SEL_CYCLES < 2) begin : g_bad_sel
    $error("mode select count must be at least two cycles");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_RDACK, ST_IGNORE
  } link_state_t;

  // system domain
  logic [1:0]    scl_sys_s;
  logic [2:0]    evt_tgl_s;
  logic [1:0]    ack_tgl_s;
  logic [CW-1:0] sel_cnt, next_sel_cnt;
  logic          sel_done, next_sel_done;
  logic          next_single_wire;
  logic          next_rx_valid;
  link_evt_t     next_rx_evt;
  logic [7:0]    tx_word, next_tx_word;
  logic          tx_req, next_tx_req;
  logic          next_tx_ready;

  // link domain
  logic [1:0]    rst_l_s;
  pins_t         pins_m, pins_s, pins_p;
  logic [1:0]    ce_l_s, two_wire_s, accept_s;
  logic [2:0]    tx_req_s;
  link_state_t   state, next_state;
  logic [3:0]    cnt, next_cnt;
  logic [7:0]    sh, next_sh;
  logic          dir, next_dir;
  logic          more, next_more;
  logic          addressed, next_addressed;
  logic          next_sda_oe;
  link_evt_t     evt, next_evt;
  logic          evt_tgl, next_evt_tgl;
  logic [7:0]    hold, next_hold;
  logic          hold_full, next_hold_full;
  logic          ack_tgl, next_ack_tgl;

  // mode select and user side, system clock
  always_comb
  begin
    next_sel_cnt     = sel_cnt;
    next_sel_done    = sel_done;
    next_single_wire = single_wire_mode;
    if (!sel_done)
    begin
      if (scl_sys_s[1])
        next_sel_done = 1'b1;
      else if (sel_cnt == CW'(MODE_SEL_CYCLES - 1))
      begin
        next_sel_done    = 1'b1;
        next_single_wire = 1'b1;
      end
      else
        next_sel_cnt = sel_cnt + 1'b1;
    end
    next_rx_valid = 1'b0;
    next_rx_evt   = rx_evt;
    if (evt_tgl_s[1] ^ evt_tgl_s[2])
    begin
      next_rx_valid = 1'b1;
      next_rx_evt   = evt;  // written with the toggle, settled once the toggle has crossed the synchroniser
    end
    next_tx_word = tx_word;
    next_tx_req  = tx_req;
    if (tx_valid && tx_ready)
    begin
      next_tx_word = tx_data;
      next_tx_req  = ~tx_req;
    end
    next_tx_ready = (next_tx_req == ack_tgl_s[1]);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_sys_s        <= 2'h0;
      evt_tgl_s        <= 3'h0;
      ack_tgl_s        <= 2'h0;
      sel_cnt          <= '0;
      sel_done         <= 1'b0;
      single_wire_mode <= 1'b0;
      rx_valid         <= 1'b0;
      rx_evt           <= '0;
      tx_word          <= 8'h00;
      tx_req           <= 1'b0;
      tx_ready         <= 1'b0;
    end
    else if (ce)
    begin
      scl_sys_s        <= {scl_sys_s[0], scl_i};
      evt_tgl_s        <= {evt_tgl_s[1:0], evt_tgl};
      ack_tgl_s        <= {ack_tgl_s[0], ack_tgl};
      sel_cnt          <= next_sel_cnt;
      sel_done         <= next_sel_done;
      single_wire_mode <= next_single_wire;
      rx_valid         <= next_rx_valid;
      rx_evt           <= next_rx_evt;
      tx_word          <= next_tx_word;
      tx_req           <= next_tx_req;
      tx_ready         <= next_tx_ready;
    end
  end

  // link reset: asserts at once, releases on the link clock
  always_ff @(posedge clk_link or negedge rstn)
  begin
    if (!rstn)
      rst_l_s <= 2'h0;
    else
      rst_l_s <= {rst_l_s[0], 1'b1};
  end

  // synchronisers run free so a frozen block still sees fresh levels
  always_ff @(posedge clk_link or negedge rst_l_s[1])
  begin
    if (!rst_l_s[1])
    begin
      pins_m     <= '1;
      pins_s     <= '1;
      ce_l_s     <= 2'h0;
      two_wire_s <= 2'h0;
      accept_s   <= 2'h0;
      tx_req_s   <= 3'h0;
    end
    else
    begin
      pins_m     <= '{scl: scl_i, sda: sda_i};
      pins_s     <= pins_m;
      ce_l_s     <= {ce_l_s[0], ce};
      two_wire_s <= {two_wire_s[0], sel_done & ~single_wire_mode};
      accept_s   <= {accept_s[0], rx_accept};
      tx_req_s   <= {tx_req_s[1:0], tx_req};
    end
  end

  // link engine
  logic      scl_rise, scl_fall, start_c, stop_c, fire, load;
  link_evt_t ev;
  logic [7:0] byte_out;

  // sampling on a rising edge of the synchronised clock, not on a level seen high
  assign scl_rise = pins_s.scl & ~pins_p.scl;
  assign scl_fall = ~pins_s.scl & pins_p.scl;
  assign start_c  = pins_s.scl & pins_p.scl & pins_p.sda
                    & ~pins_s.sda;
  assign stop_c   = pins_s.scl & pins_p.scl & ~pins_p.sda
                    & pins_s.sda;
  assign byte_out = hold_full ? hold : TX_IDLE_BYTE;

  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_sh        = sh;
    next_dir       = dir;
    next_more      = more;
    next_addressed = addressed;
    next_sda_oe    = sda_oe;
    next_evt       = evt;
    next_evt_tgl   = evt_tgl;
    next_hold      = hold;
    next_hold_full = hold_full;
    next_ack_tgl   = ack_tgl;
    fire           = 1'b0;
    load           = 1'b0;
    ev             = evt;
    unique case (state)
      ST_IDLE, ST_IGNORE: ;
      ST_ADDR:
      begin
        if (scl_rise)
        begin
          next_sh  = {sh[6:0], pins_s.sda};
          next_cnt = cnt + 1'b1;
        end
        if (scl_fall && cnt == BIT_CNT_LAST)
        begin
          if (sh[7:1] == DEV_ADDR_BYTE[7:1])
          begin
            next_sda_oe    = 1'b1;
            next_dir       = sh[0];
            next_addressed = 1'b1;
            next_state     = ST_ACK;
            fire           = 1'b1;
            ev             = '{kind: EV_ADDR, data: sh};
          end
          else
            next_state = ST_IGNORE;          // ten-bit heads never match
        end
      end
      ST_ACK:
        if (scl_fall)
        begin
          next_cnt = 4'h0;
          if (dir == DIR_READ)
          begin
            load        = 1'b1;
            next_sh     = byte_out;
            next_sda_oe = ~byte_out[7];
            next_state  = ST_RD;
          end
          else
          begin
            next_sda_oe = 1'b0;
            next_state  = ST_WR;
          end
        end
      ST_WR:
      begin
        if (scl_rise)
        begin
          next_sh  = {sh[6:0], pins_s.sda};
          next_cnt = cnt + 1'b1;
        end
        if (scl_fall && cnt == BIT_CNT_LAST)
        begin
          next_sda_oe = accept_s[1];
          next_state  = ST_ACK;
          fire        = 1'b1;
          ev          = '{kind: EV_DATA, data: sh};
        end
      end
      ST_RD:
      begin
        if (scl_rise)
          next_cnt = cnt + 1'b1;
        if (scl_fall)
        begin
          if (cnt == BIT_CNT_LAST)
          begin
            next_sda_oe = 1'b0;
            next_state  = ST_RDACK;
          end
          else
          begin
            next_sh     = {sh[6:0], 1'b0};
            next_sda_oe = ~sh[6];
          end
        end
      end
      ST_RDACK:
      begin
        if (scl_rise)
          next_more = (pins_s.sda == ACK_LEVEL);
        if (scl_fall)
        begin
          if (more)
          begin
            load        = 1'b1;
            next_sh     = byte_out;
            next_sda_oe = ~byte_out[7];
            next_cnt    = 4'h0;
            next_state  = ST_RD;
          end
          else
          begin
            fire       = 1'b1;                   // master refused
            ev         = '{kind: EV_NACK, data: sh};
            next_state = ST_IGNORE;
          end
        end
      end
    endcase
    if (start_c)
    begin
      next_state     = ST_ADDR;
      next_cnt       = 4'h0;
      next_sda_oe    = 1'b0;
      next_addressed = 1'b0;
    end
    else if (stop_c)
    begin
      next_state     = ST_IDLE;
      next_sda_oe    = 1'b0;
      next_addressed = 1'b0;
      if (addressed)
      begin
        fire = 1'b1;
        ev   = '{kind: EV_STOP, data: 8'h00};
      end
    end
    if (!two_wire_s[1])
    begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end
    if (fire)
    begin
      next_evt     = ev;
      next_evt_tgl = ~evt_tgl;
    end
    if (load && hold_full)
    begin
      next_hold_full = 1'b0;
      next_ack_tgl   = ~ack_tgl;
    end
    if (tx_req_s[1] ^ tx_req_s[2])
    begin
      next_hold      = tx_word;  // held by the system side until acked
      next_hold_full = 1'b1;
    end
  end

  always_ff @(posedge clk_link or negedge rst_l_s[1])
  begin
    if (!rst_l_s[1])
    begin
      pins_p    <= '1;
      state     <= ST_IDLE;
      cnt       <= 4'h0;
      sh        <= 8'h00;
      dir       <= 1'b0;
      more      <= 1'b0;
      addressed <= 1'b0;
      sda_oe    <= 1'b0;
      sda_o     <= 1'b0;
      evt       <= '0;
      evt_tgl   <= 1'b0;
      hold      <= 8'h00;
      hold_full <= 1'b0;
      ack_tgl   <= 1'b0;
    end
    else if (ce_l_s[1])
    begin
      pins_p    <= pins_s;
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= next_sh;
      dir       <= next_dir;
      more      <= next_more;
      addressed <= next_addressed;
      sda_oe    <= next_sda_oe;
      sda_o     <= 1'b0;     // open drain: only ever pulls low
      evt       <= next_evt;
      evt_tgl   <= next_evt_tgl;
      hold      <= next_hold;
      hold_full <= next_hold_full;
      ack_tgl   <= next_ack_tgl;
    end
  end

endmodule // sensor_i2c_slave_link

// *** hdl/sensor_i2c_pkg.sv ***
// shared constants and carrier types of the sensor two-wire slave link
package sensor_i2c_pkg;
  localparam logic [7:0] DEV_ADDR_BYTE = 8'hb8;  // direction bit zero
  localparam int         BYTE_BITS     = 8;
  localparam logic [3:0] BIT_CNT_LAST  = 4'h8;
  localparam logic [7:0] TX_IDLE_BYTE  = 8'hff;   // sent when no word queued
  localparam logic       ACK_LEVEL     = 1'b0;
  localparam logic       DIR_READ      = 1'b1;
  localparam longint     CLK_SYS_HZ    = 100_000_000;
  localparam longint     MODE_SEL_MS   = 500;
  localparam longint     MODE_SEL_CYC  = (MODE_SEL_MS * CLK_SYS_HZ) / 1000;

  typedef enum logic [1:0] {EV_ADDR, EV_DATA, EV_STOP, EV_NACK} evt_kind_t;

  typedef struct packed {
    evt_kind_t  kind;
    logic [7:0] data;
  } link_evt_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } pins_t;
endpackage

// *** verification/sensor_i2c_link_monitor.sv ***
// port-level assertion checker for the two-wire slave link
`timescale 1ns/1ps

module sensor_i2c_link_monitor
  import sensor_i2c_pkg::*;
#(
  parameter int unsigned MODE_SEL_CYCLES = 20
)(
  input wire logic       clk_sys,          // system clock
  input wire logic       rstn,             // reset, active low
  input wire logic       clk_link,         // link clock
  input wire logic       scl_i,            // clock pin
  input wire logic       sda_i,            // data pin
  input wire logic       sda_o,            // data drive value
  input wire logic       sda_oe,           // data pull enable
  input wire logic       single_wire_mode, // mode choice
  input wire logic       rx_valid,         // event pulse
  input wire link_evt_t  rx_evt,           // event
  input wire logic       tx_valid,         // read byte offered
  input wire logic       tx_ready          // slot free
);
  // raw scl is checked: the drive lags the pin by the two synchroniser flops and the drive register
  AST_OE_LOW_ONLY: assert property (@(posedge clk_link)
    disable iff (!rstn) $changed(sda_oe) |-> !scl_i)
    else $error("data drive changed while clock high");
  AST_DRIVE_LOW: assert property (@(posedge clk_link)
    disable iff (!rstn) sda_oe |-> sda_o == 1'b0)
    else $error("data line driven high");
  AST_SINGLE_QUIET: assert property (@(posedge clk_sys)
    disable iff (!rstn) single_wire_mode |-> !sda_oe)
    else $error("data driven in single wire mode");
  AST_SINGLE_KEEP: assert property (@(posedge clk_sys)
    disable iff (!rstn) single_wire_mode |=> single_wire_mode)
    else $error("mode choice changed");
  AST_RX_PULSE: assert property (@(posedge clk_sys)
    disable iff (!rstn) rx_valid |=> !rx_valid [*4])
    else $error("event pulse too long or too close");
  AST_EVT_HOLD: assert property (@(posedge clk_sys)
    disable iff (!rstn) !rx_valid |-> $stable(rx_evt))
    else $error("event changed without pulse");
  AST_ADDR_MATCH: assert property (@(posedge clk_sys)
    disable iff (!rstn) rx_valid && rx_evt.kind == EV_ADDR
    |-> rx_evt.data[7:1] == DEV_ADDR_BYTE[7:1])
    else $error("foreign address reported");
  AST_STOP_LEVEL: assert property (@(posedge clk_sys)
    disable iff (!rstn) rx_valid && rx_evt.kind == EV_STOP
    |-> sda_i && scl_i)
    else $error("stop event without idle lines");
  AST_TX_TAKE: assert property (@(posedge clk_sys)
    disable iff (!rstn) tx_valid && tx_ready |=> !tx_ready)
    else $error("slot still free after take");
endmodule // sensor_i2c_link_monitor

bind sensor_i2c_slave_link sensor_i2c_link_monitor #(
  .MODE_SEL_CYCLES(MODE_SEL_CYCLES)
) u_mon (
  .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .single_wire_mode(single_wire_mode), .rx_valid(rx_valid),
  .rx_evt(rx_evt), .tx_valid(tx_valid), .tx_ready(tx_ready)
);

// *** verification/i2c_host_model.sv ***
// two-wire bus master model standing for the host controller
`timescale 1ns/1ps

module i2c_host_model #(
  parameter int QTR = 2500  // quarter bit in ns, 100 kb/s
)(
  output logic      scl,  // serial clock, idle high
  output logic      oe,   // pulls data low when high
  input  wire logic sda   // resolved data wire
);
  initial
  begin
    scl = 1'b1;
    oe  = 1'b0;
  end

  task automatic set_scl(input logic v);
    scl = v;
  endtask

  // one slot: data set in clock low, one pulse per bit
  task automatic slot(input logic pull, output logic got);
    oe = pull;
    #QTR scl = 1'b1;
    #QTR got = sda;  // level taken mid high
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic start();
    oe = 1'b1;
    #(2*QTR) scl = 1'b0;
    #QTR;
  endtask

  task automatic stop();
    oe = 1'b1;
    #QTR scl = 1'b1;
    #(2*QTR) oe = 1'b0;
    #(2*QTR);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      slot(!b[i], s);
    slot(1'b0, ack);  // released for the answer
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      slot(1'b0, b[i]);
    slot(!last, s);
  endtask
endmodule // i2c_host_model

// *** verification/sensor_i2c_slave_link_tb.sv ***
// self-checking bench for the two-wire slave link
`timescale 1ns/1ps

module sensor_i2c_slave_link_tb
  import sensor_i2c_pkg::*;
;
  logic        clk_sys;
  logic        clk_link;
  logic        rstn;
  logic        rx_accept;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        sda_o;
  logic        sda_oe;
  logic        single_wire_mode;
  logic        rx_valid;
  link_evt_t   rx_evt;
  logic        tx_ready;
  logic        scl;
  logic        host_oe;
  wire         sda = !(sda_oe || host_oe);
  int          mismatches;
  int          num_checks;
  logic [31:0] lfsr;
  logic [9:0]  exp_q[$];
  logic [9:0]  e;
  logic        ack;
  logic [7:0]  b;
  logic [7:0]  w;

  initial clk_sys = 1'b0;
  always #5 clk_sys = !clk_sys;
  initial
  begin
    clk_link = 1'b0;
    #2.1;
    forever #7.5 clk_link = !clk_link;
  end

  sensor_i2c_slave_link #(.MODE_SEL_CYCLES(20)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .clk_link(clk_link),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .single_wire_mode(single_wire_mode), .rx_valid(rx_valid),
    .rx_evt(rx_evt), .rx_accept(rx_accept), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  i2c_host_model u_host (.scl(scl), .oe(host_oe), .sda(sda));

  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // every event is matched against the queue of expected ones
  always @(posedge clk_sys)
    if (rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray event", 16'(rx_evt), 16'hffff);
      else
      begin
        e = exp_q.pop_front();
        check("event kind", 16'(rx_evt.kind), 16'(e[9:8]));
        if (e[9] == 1'b0)
          check("event data", 16'(rx_evt.data), 16'(e[7:0]));
      end
    end

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("events left", 16'(exp_q.size()), 16'h0000);
  endtask

  task automatic offer(input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    tx_valid <= 1'b1;
    tx_data  <= v;
    @(posedge clk_sys);
    while (tx_ready !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    tx_valid <= 1'b0;
    check("slot free", 16'(tx_ready), 16'h0001);
  endtask

  initial
  begin
    #1ms;
    mismatches++;
    end_sim();
  end

  initial
  begin
    rstn = 1'b0;
    rx_accept = 1'b1;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    mismatches = 0;
    num_checks = 0;
    lfsr = step(32'h3055);
    repeat (5) @(posedge clk_sys);
    u_host.set_scl(1'b0);  // after the model's own idle-high start
    rstn <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check("single wire", 16'(single_wire_mode), 16'h0001);
    rstn <= 1'b0;
    u_host.set_scl(1'b1);
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check("two wire", 16'(single_wire_mode), 16'h0000);
    u_host.start();
    exp_q.push_back({EV_ADDR, DEV_ADDR_BYTE});
    u_host.wr_byte(DEV_ADDR_BYTE, ack);
    check("addr ack", 16'(ack), 16'(ACK_LEVEL));
    exp_q.push_back({EV_DATA, lfsr[7:0]});
    u_host.wr_byte(lfsr[7:0], ack);
    check("data ack", 16'(ack), 16'(ACK_LEVEL));
    @(posedge clk_sys);
    rx_accept <= 1'b0;
    exp_q.push_back({EV_DATA, lfsr[15:8]});
    u_host.wr_byte(lfsr[15:8], ack);
    check("full nack", 16'(ack), 16'(!ACK_LEVEL));
    exp_q.push_back({EV_STOP, 8'h00});
    u_host.stop();
    drain();
    @(posedge clk_sys);
    rx_accept <= 1'b1;
    lfsr = step(lfsr);
    w = lfsr[7:0];  // asymmetric bit pattern exposes a reversed order
    offer(w);
    u_host.start();
    exp_q.push_back({EV_ADDR, DEV_ADDR_BYTE | 8'h01});
    u_host.wr_byte(DEV_ADDR_BYTE | 8'h01, ack);
    check("read ack", 16'(ack), 16'(ACK_LEVEL));
    u_host.rd_byte(1'b0, b);
    check("read byte", 16'(b), 16'(w));
    check("slot back", 16'(tx_ready), 16'h0001);
    exp_q.push_back({EV_NACK, 8'h00});
    u_host.rd_byte(1'b1, b);
    check("idle byte", 16'(b), 16'(TX_IDLE_BYTE));
    exp_q.push_back({EV_STOP, 8'h00});
    u_host.stop();
    drain();
    u_host.start();
    u_host.wr_byte(8'hf1, ack);
    check("foreign nack", 16'(ack), 16'(!ACK_LEVEL));
    u_host.stop();
    repeat (20) @(posedge clk_sys);
    drain();
    end_sim();
  end
endmodule // sensor_i2c_slave_link_tb
